// File: tpi_pin_model.sv
`timescale 1ns/100ps
module tpi_pin_model (
	input  wire logic       mclk,
	input  wire logic       run,
	input  wire logic [3:0] half,
	output logic            pin
);
	logic [3:0] cnt_q = 4'h0;
	logic       lvl_q = 1'b0;
	assign pin = lvl_q;
	// toggles every half clocks in a frame, holds level between frames
	always @(posedge mclk) begin
		if (run) begin
			if (cnt_q + 4'h1 >= half) begin
				lvl_q <= ~lvl_q;
				cnt_q <= 4'h0;
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end
endmodule : tpi_pin_model

// File: tpi_pkg.sv
package tpi_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] FLAGS_OFS    = 8'h36;
	localparam logic [7:0] GTC_OFS      = 8'h43;
	localparam logic [7:0] MASK_OFS     = 8'h6F;
	localparam logic [7:0] CTRL_OFS     = 8'h81;
	localparam logic [7:0] FLAGS_RST    = 8'h00;
	localparam logic [7:0] GTC_RST      = 8'h00;
	localparam logic [7:0] MASK_RST     = 8'h00;
	localparam logic [7:0] CTRL_RST     = 8'h00;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int FLG_CAP  = 5;
	localparam int FLG_CMPB = 2;
	localparam int FLG_CMPA = 1;
	localparam int FLG_OVF  = 0;
	localparam logic [7:0] FLAGS_USED = 8'h27;
	localparam int GTC_SYNC = 7;
	localparam int GTC_ASYR = 1;
	localparam int GTC_PSR  = 0;
	localparam int MSK_CAP  = 5;
	localparam int MSK_CMPB = 2;
	localparam int MSK_CMPA = 1;
	localparam int MSK_OVF  = 0;
	// ---------------------------------------------------------------
	// clock select codes and prescaler
	// ---------------------------------------------------------------
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_D64  = 3'h3;
	localparam logic [2:0] CS_D256 = 3'h4;
	localparam logic [2:0] CS_D1K  = 3'h5;
	localparam logic [2:0] CS_FALL = 3'h6;
	localparam logic [2:0] CS_RISE = 3'h7;
	localparam int PRE_W = 10;
	localparam logic [PRE_W-1:0] PRE_RST = 10'h000;
endpackage : tpi_pkg

// File: tpi_timer_ctl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - compare-A irq needs enable, global, flag
// - overflow irq needs enable, global, flag
// - flag bits 5,2,1,0; others read zero
// - capture flag from pin or top
// - flags clear on vector or written one
// - compare flags set cycle after match
// - overflow flag follows waveform mode event
// - two timers share one prescaler
// - select 1 direct; taps 8/64/256/1024
// - prescaler free-running, ignores clock select
// - prescaler reset restarts all timers
// - pin latched high phase, then registered
// - select 7 rising, 6 falling edges
// - count 2.5 to 3.5 clocks after edge
// - external edges bypass prescaler
// - sync mode holds reset bits; clear releases
// - prescaler reset bit self-clears unless sync
// - select 0 stops the counter
module tpi_timer_ctl
	import tpi_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       global_irq_en,
	input  wire logic       vec_cap_ack,
	input  wire logic       vec_cmpb_ack,
	input  wire logic       vec_cmpa_ack,
	input  wire logic       vec_ovf_ack,
	input  wire logic       cap_event,
	input  wire logic       cap_is_top,
	input  wire logic       top_reached,
	input  wire logic       cmpa_match,
	input  wire logic       cmpb_match,
	input  wire logic       ovf_event,
	input  wire logic [2:0] t0_clock_select,
	input  wire logic       external_count_clock_pin,
	output logic            irq_cap,
	output logic            irq_cmpb,
	output logic            irq_cmpa,
	output logic            irq_ovf,
	output logic            t1_tick,
	output logic            t0_tick,
	output logic            async_prescaler_reset
);
	import tpi_pkg::*;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0]       flags_q, flags_d;
	logic [7:0]       mask_q;
	logic [2:0]       cs_q;
	logic             sync_q, psr_q, asyr_q;
	logic [PRE_W-1:0] pre_q;
	logic             pin_lat, pin_s1_q, pin_s2_q, pin_prev_q;
	logic [7:0]       rdata_q;

	wire wr_flags = wr && (addr == FLAGS_OFS);
	wire wr_gtc   = wr && (addr == GTC_OFS);
	wire wr_mask  = wr && (addr == MASK_OFS);
	wire wr_ctrl  = wr && (addr == CTRL_OFS);

	// ---------------------------------------------------------------
	// prescaler
	// ---------------------------------------------------------------
	wire pre_hold = psr_q;
	wire tap8   = (pre_q[2:0] == 3'h7);
	wire tap64  = (pre_q[5:0] == 6'h3F);
	wire tap256 = (pre_q[7:0] == 8'hFF);
	wire tap1k  = (pre_q == 10'h3FF);

	always_ff @(posedge mclk) begin
		if (!nrst || pre_hold)
			pre_q <= PRE_RST;
		else
			pre_q <= pre_q + 10'h001;
	end

	// ---------------------------------------------------------------
	// external pin sampling
	// ---------------------------------------------------------------
	always_latch begin
		if (mclk)
			pin_lat = external_count_clock_pin;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pin_s1_q   <= 1'b0;
			pin_s2_q   <= 1'b0;
			pin_prev_q <= 1'b0;
		end else begin
			pin_s1_q   <= pin_lat;
			pin_s2_q   <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	wire ext_rise = pin_s2_q && !pin_prev_q;
	wire ext_fall = !pin_s2_q && pin_prev_q;

	// ---------------------------------------------------------------
	// clock select
	// ---------------------------------------------------------------
	function automatic logic pick(input logic [2:0] cs, input logic hold);
		logic r;
		r = 1'b0;
		unique case (cs)
			CS_STOP: r = 1'b0;
			CS_DIV1: r = !hold;
			CS_DIV8: r = !hold && tap8;
			CS_D64:  r = !hold && tap64;
			CS_D256: r = !hold && tap256;
			CS_D1K:  r = !hold && tap1k;
			CS_FALL: r = ext_fall;
			CS_RISE: r = ext_rise;
		endcase
		return r;
	endfunction : pick

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			t1_tick <= 1'b0;
			t0_tick <= 1'b0;
		end else begin
			t1_tick <= pick(cs_q, pre_hold);
			t0_tick <= pick(t0_clock_select, pre_hold);
		end
	end

	// ---------------------------------------------------------------
	// flags
	// ---------------------------------------------------------------
	wire cap_set = cap_is_top ? top_reached : cap_event;
	wire [7:0] set_v = {2'b00, cap_set, 2'b00, cmpb_match, cmpa_match, ovf_event};
	wire [7:0] ack_v = {2'b00, vec_cap_ack, 2'b00, vec_cmpb_ack, vec_cmpa_ack, vec_ovf_ack};
	wire [7:0] wclr  = wr_flags ? wdata : 8'h00;

	always_comb begin
		flags_d = ((flags_q & ~(ack_v | wclr)) | set_v) & FLAGS_USED;
	end

	always_ff @(posedge mclk) begin
		if (!nrst)
			flags_q <= FLAGS_RST;
		else
			flags_q <= flags_d;
	end

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			mask_q <= MASK_RST;
			cs_q   <= CTRL_RST[2:0];
		end else begin
			if (wr_mask)
				mask_q <= wdata & FLAGS_USED;
			if (wr_ctrl)
				cs_q <= wdata[2:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sync_q <= GTC_RST[GTC_SYNC];
			psr_q  <= GTC_RST[GTC_PSR];
			asyr_q <= GTC_RST[GTC_ASYR];
		end else if (wr_gtc) begin
			sync_q <= wdata[GTC_SYNC];
			psr_q  <= wdata[GTC_PSR];
			asyr_q <= wdata[GTC_ASYR] && wdata[GTC_SYNC];
		end else if (!sync_q) begin
			psr_q  <= 1'b0;
			asyr_q <= 1'b0;
		end
	end

	assign async_prescaler_reset = asyr_q;

	// ---------------------------------------------------------------
	// interrupt requests
	// ---------------------------------------------------------------
	assign irq_cmpa = global_irq_en && mask_q[MSK_CMPA] && flags_q[FLG_CMPA];
	assign irq_ovf  = global_irq_en && mask_q[MSK_OVF] && flags_q[FLG_OVF];
	assign irq_cmpb = global_irq_en && mask_q[MSK_CMPB] && flags_q[FLG_CMPB];
	assign irq_cap  = global_irq_en && mask_q[MSK_CAP] && flags_q[FLG_CAP];

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	wire [7:0] rd_mux =
		(addr == FLAGS_OFS) ? flags_q :
		(addr == MASK_OFS)  ? mask_q :
		(addr == CTRL_OFS)  ? {5'h00, cs_q} :
		(addr == GTC_OFS)   ? {sync_q, 5'h00, asyr_q, psr_q} : 8'h00;

	always_ff @(posedge mclk) begin
		if (!nrst)
			rdata_q <= 8'h00;
		else
			rdata_q <= rd ? rd_mux : 8'h00;
	end

	assign rdata = rdata_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_cmpa_irq;
		@(posedge mclk) disable iff (!nrst)
		cmpa_match ##1 (global_irq_en && mask_q[MSK_CMPA]) |-> irq_cmpa;
	endproperty
	a_cmpa_irq: assert property (p_cmpa_irq) else $error("cmpa irq missing");

	property p_ovf_irq;
		@(posedge mclk) disable iff (!nrst)
		(!global_irq_en || !mask_q[MSK_OVF]) |-> !irq_ovf;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("ovf irq unmasked");

	property p_resv;
		@(posedge mclk) disable iff (!nrst)
		$past(rd) && $past(addr) == FLAGS_OFS |-> rdata[7:6] == 2'b00 && rdata[4:3] == 2'b00;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved flag bit set");

	property p_cmpa_set;
		@(posedge mclk) disable iff (!nrst)
		cmpa_match |=> flags_q[FLG_CMPA];
	endproperty
	a_cmpa_set: assert property (p_cmpa_set) else $error("match flag not set");

	property p_clr;
		@(posedge mclk) disable iff (!nrst)
		wr_flags && wdata[FLG_OVF] && !ovf_event |=> !flags_q[FLG_OVF];
	endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");

	property p_stop;
		@(posedge mclk) disable iff (!nrst)
		$past(cs_q) == CS_STOP |-> !t1_tick;
	endproperty
	a_stop: assert property (p_stop) else $error("stopped timer ticked");

	property p_psr_self;
		@(posedge mclk) disable iff (!nrst)
		psr_q && !sync_q && !wr_gtc |=> !psr_q;
	endproperty
	a_psr_self: assert property (p_psr_self) else $error("psr stuck");

	property p_hold;
		@(posedge mclk) disable iff (!nrst)
		sync_q && psr_q && !wr_gtc |=> psr_q && pre_q == PRE_RST;
	endproperty
	a_hold: assert property (p_hold) else $error("sync hold lost");

	property p_div8;
		@(posedge mclk) disable iff (!nrst)
		$past(cs_q) == CS_DIV8 && cs_q == CS_DIV8 && t1_tick && !psr_q ##1
			(cs_q == CS_DIV8 && !psr_q)[*7] |-> !t1_tick;
	endproperty
	a_div8: assert property (p_div8) else $error("div8 too fast");

	property p_ext;
		@(posedge mclk) disable iff (!nrst)
		cs_q == CS_RISE && ext_rise |=> t1_tick;
	endproperty
	a_ext: assert property (p_ext) else $error("edge lost");

	property p_ovf_req;
		@(posedge mclk) disable iff (!nrst)
		ovf_event ##1 (global_irq_en && mask_q[MSK_OVF]) |-> irq_ovf;
	endproperty
	a_ovf_req: assert property (p_ovf_req) else $error("ovf irq missing");

	property p_cmpb_set;
		@(posedge mclk) disable iff (!nrst)
		cmpb_match |=> flags_q[FLG_CMPB];
	endproperty
	a_cmpb_set: assert property (p_cmpb_set) else $error("cmpb flag not set");

	property p_cap_top;
		@(posedge mclk) disable iff (!nrst)
		cap_is_top && top_reached |=> flags_q[FLG_CAP];
	endproperty
	a_cap_top: assert property (p_cap_top) else $error("capture flag not set at top");

	property p_cap_pin;
		@(posedge mclk) disable iff (!nrst)
		!cap_is_top && cap_event |=> flags_q[FLG_CAP];
	endproperty
	a_cap_pin: assert property (p_cap_pin) else $error("capture flag not set");

	property p_ack;
		@(posedge mclk) disable iff (!nrst)
		vec_cmpa_ack && !cmpa_match |=> !flags_q[FLG_CMPA];
	endproperty
	a_ack: assert property (p_ack) else $error("vector did not clear flag");

	property p_ack_cap;
		@(posedge mclk) disable iff (!nrst)
		vec_cap_ack && !cap_set |=> !flags_q[FLG_CAP];
	endproperty
	a_ack_cap: assert property (p_ack_cap) else $error("vector did not clear capture");

	property p_keep;
		@(posedge mclk) disable iff (!nrst)
		wr_flags && !wdata[FLG_CMPB] && flags_q[FLG_CMPB] && !vec_cmpb_ack |=> flags_q[FLG_CMPB];
	endproperty
	a_keep: assert property (p_keep) else $error("written zero cleared flag");

	property p_fall;
		@(posedge mclk) disable iff (!nrst)
		cs_q == CS_FALL && ext_fall |=> t1_tick;
	endproperty
	a_fall: assert property (p_fall) else $error("falling edge lost");

	property p_latency;
		@(posedge mclk) disable iff (!nrst)
		cs_q == CS_RISE && $rose(pin_s1_q) ##1 cs_q == CS_RISE |=> t1_tick;
	endproperty
	a_latency: assert property (p_latency) else $error("pin edge late");

	property p_ext_direct;
		@(posedge mclk) disable iff (!nrst)
		cs_q == CS_RISE && ext_rise && psr_q |=> t1_tick;
	endproperty
	a_ext_direct: assert property (p_ext_direct) else $error("edge held by prescaler");

	property p_release;
		@(posedge mclk) disable iff (!nrst)
		wr_gtc && !wdata[GTC_SYNC] ##1 !wr_gtc |=> !psr_q && !asyr_q;
	endproperty
	a_release: assert property (p_release) else $error("reset bits not released");

	property p_pre_rst;
		@(posedge mclk) disable iff (!nrst)
		psr_q |=> pre_q == PRE_RST;
	endproperty
	a_pre_rst: assert property (p_pre_rst) else $error("prescaler not cleared");

	property p_pre_run;
		@(posedge mclk) disable iff (!nrst)
		!psr_q |=> pre_q == $past(pre_q) + 10'h001;
	endproperty
	a_pre_run: assert property (p_pre_run) else $error("prescaler not running");

	property p_div1;
		@(posedge mclk) disable iff (!nrst)
		cs_q == CS_DIV1 && !psr_q |=> t1_tick;
	endproperty
	a_div1: assert property (p_div1) else $error("direct clock missing");

	property p_t0_stop;
		@(posedge mclk) disable iff (!nrst)
		t0_clock_select == CS_STOP |=> !t0_tick;
	endproperty
	a_t0_stop: assert property (p_t0_stop) else $error("stopped 8-bit timer ticked");

	c_ovf_irq: cover property (@(posedge mclk) disable iff (!nrst) irq_ovf);
	c_release: cover property (@(posedge mclk) disable iff (!nrst) sync_q ##1 !sync_q);
	c_vec:     cover property (@(posedge mclk) disable iff (!nrst) vec_ovf_ack && flags_q[FLG_OVF]);
	c_ext:     cover property (@(posedge mclk) disable iff (!nrst) cs_q == CS_FALL && t1_tick);
	c_sync:    cover property (@(posedge mclk) disable iff (!nrst) sync_q && psr_q);
endmodule : tpi_timer_ctl

// File: tpi_timer_ctl_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("Error %0t: got %h exp %h", $time, a, b); end end
module tpi_timer_ctl_tb;
	import tpi_pkg::*;
	logic       mclk = 0, nrst = 0, wr = 0, rd = 0, g = 0, ct = 0, run = 0, cnt_en = 0;
	logic       pin_p = 0, pin, irq_cap, irq_cmpb, irq_cmpa, irq_ovf, t1_tick, t0_tick;
	logic [7:0] addr = 0, wdata = 0, rdata, d, x, m, w;
	logic [4:0] ev = 0;
	logic [3:0] ack = 0;
	logic [2:0] t0_cs = 0;
	logic [4:0] re;
	logic       asr;
	int         mismatches = 0, n_checks = 0;
	integer     n1, n0, nr, nf;
	always #2.5 mclk = ~mclk;
	tpi_pin_model u_tpi_pin_model (.mclk(mclk), .run(run), .half(4'h3), .pin(pin));
	tpi_timer_ctl u_tpi_timer_ctl (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .global_irq_en(g), .vec_cap_ack(ack[3]),
		.vec_cmpb_ack(ack[2]), .vec_cmpa_ack(ack[1]), .vec_ovf_ack(ack[0]),
		.cap_event(ev[4]), .cap_is_top(ct), .top_reached(ev[3]), .cmpa_match(ev[2]),
		.cmpb_match(ev[1]), .ovf_event(ev[0]), .t0_clock_select(t0_cs),
		.external_count_clock_pin(pin), .irq_cap(irq_cap), .irq_cmpb(irq_cmpb),
		.irq_cmpa(irq_cmpa), .irq_ovf(irq_ovf), .t1_tick(t1_tick), .t0_tick(t0_tick),
		.async_prescaler_reset(asr));
	always @(posedge mclk) begin
		if (cnt_en) begin
			n1 = n1 + t1_tick;
			n0 = n0 + t0_tick;
			nr += int'(pin & ~pin_p); nf += int'(~pin & pin_p);
		end
		pin_p = pin;
	end
	task bus_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk); addr <= a; wdata <= v; wr <= 1;
		@(posedge mclk); wr <= 0;
	endtask : bus_wr
	task bus_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk); addr <= a; rd <= 1;
		@(posedge mclk); rd <= 0;
		#1 v = rdata;
	endtask : bus_rd
	task pulse(input logic [4:0] e, input logic [3:0] k);
		@(posedge mclk); ev <= e; ack <= k;
		@(posedge mclk); ev <= 0; ack <= 0;
	endtask : pulse
	task win(input int len, input logic ext);
		@(posedge mclk); n1 = 0; n0 = 0; nr = 0; nf = 0; cnt_en <= 1; run <= ext;
		repeat (len) @(posedge mclk);
		run <= 0;
		repeat (ext ? 8 : 0) @(posedge mclk);
		cnt_en <= 0;
		@(posedge mclk);
	endtask : win
	function automatic int exp_ticks(input logic [2:0] cs);
		case (cs)
			CS_DIV1: return 1024;
			CS_DIV8: return 128;
			CS_D64:  return 16;
			CS_D256: return 4;
			CS_D1K:  return 1;
			default: return 0;
		endcase
	endfunction : exp_ticks
	function automatic logic [7:0] exp_fl(input logic [4:0] e, input logic c);
		return {2'b00, c ? e[3] : e[4], 2'b00, e[1], e[2], e[0]};
	endfunction : exp_fl
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		finish_test;
	end
	initial begin
		void'($urandom(32'ha582));
		repeat (12) @(posedge mclk);
		nrst <= 1;
		bus_rd(FLAGS_OFS, d); `CHK(d, FLAGS_RST)
		bus_rd(GTC_OFS, d); `CHK(d, GTC_RST)
		bus_wr(8'h00, 8'hff); bus_rd(8'h00, d); `CHK(d, 8'h00)
		// random events, mask, global enable and write-one clears
		repeat (24) begin
			re = 5'($urandom); ct <= 1'($urandom); g <= 1'($urandom); m = 8'($urandom);
			bus_wr(MASK_OFS, m); bus_rd(MASK_OFS, d); `CHK(d, m & FLAGS_USED)
			pulse(re, 4'h0);
			bus_rd(FLAGS_OFS, d); x = exp_fl(re, ct); `CHK(d, x)
			w = x & m & {8{g}};
			`CHK({irq_cap, irq_cmpb, irq_cmpa, irq_ovf}, {w[5], w[2:0]})
			w = 8'($urandom); bus_wr(FLAGS_OFS, w);
			bus_rd(FLAGS_OFS, d); `CHK(d, x & ~w)
			bus_wr(FLAGS_OFS, 8'hff);
		end
		// vector execution clears one flag each
		ct <= 0; pulse(5'h17, 4'h0); x = 8'h27;
		for (int i = 0; i < 4; i++) begin
			w = 8'(1 << i); pulse(5'h00, w[3:0]);
			x = x & ~{2'b00, w[3], 2'b00, w[2:0]};
			bus_rd(FLAGS_OFS, d); `CHK(d, x)
		end
		// every internal select, both timers on one prescaler
		for (int i = 0; i < 6; i++) begin
			t0_cs <= 3'(5 - i); bus_wr(CTRL_OFS, 8'(i)); bus_wr(GTC_OFS, 8'h01);
			bus_rd(GTC_OFS, d); `CHK(d, 8'h00)
			win(1024, 0);
			`CHK(n1, exp_ticks(3'(i)))
			`CHK(n0, exp_ticks(3'(5 - i)))
		end
		// sync mode holds both reset bits and halts prescaled timers
		bus_wr(GTC_OFS, 8'h83); bus_rd(GTC_OFS, d); `CHK(d, 8'h83)
		`CHK(asr, 1'b1)
		bus_wr(CTRL_OFS, {5'h00, CS_DIV8}); win(256, 0); `CHK(n1, 0)
		// external pin, rising edges through a held prescaler, then falling
		bus_wr(CTRL_OFS, {5'h00, CS_RISE}); win(297, 1); `CHK(n1, nr)
		`CHK(nr, 50)
		bus_wr(GTC_OFS, 8'h00); bus_rd(GTC_OFS, d); `CHK(d, 8'h00)
		`CHK(asr, 1'b0)
		bus_wr(CTRL_OFS, {5'h00, CS_FALL}); win(297, 1); `CHK(n1, nf)
		`CHK(nf, 50)
		finish_test;
	end
endmodule : tpi_timer_ctl_tb
